// file: rtl/wwt_cfg.svh
// constants of the window timer block
// Contract
// - tick is bus clock divided by 4096, then by 1, 2, 4 or 8.
// - 14-bit down-counter decrements every tick, active or not.
// - activation bit set by software only; stays set until reset.
// - while active, reset request when count goes from 0x40 to 0x3F.
// - while active, refresh with count above window value requests reset.
// - 14-bit window value is upper limit of refresh window.
// - started and enabled: interrupt when counter reaches 0x40; code raises it on the 0x40 to 0x3F tick, with the reset request.
// - writing zero clears early flag; writing one leaves it.
// - timeout counts ticks down to 0x3F inclusive.
// - debug halt with freeze control one stops the counter.
// - early flag set at 0x40 even with interrupt disabled.
// - early interrupt enable set by software, cleared only by reset.
// - timebase select 00 by 1, 01 by 2, 10 by 4, 11 by 8.
`ifndef WWT_CFG_SVH
`define WWT_CFG_SVH
`define WWT_OFS_CTRL 4'h0
`define WWT_OFS_CFG 4'h4
`define WWT_OFS_STS 4'h8
`define WWT_OFS_IEN 4'hC
`define WWT_BIT_ACT 14
`define WWT_BIT_EWI 16
`define WWT_PRE_DIV 4096
`define WWT_CNT_RST 14'h3FFF
`define WWT_WIN_RST 14'h3FFF
`define WWT_CNT_EARLY 14'h0040
`define WWT_CNT_LAST 14'h003F
`endif

// file: rtl/wwt_pkg.sv
// types of the window timer block
package wwt_pkg;
  typedef struct packed {
    logic [11:0] pre;
    logic [2:0] sub;
    logic [13:0] cnt;
    logic [13:0] win;
    logic [1:0] tb;
    logic act;
    logic ewi;
    logic flag;
    logic rst_req;
    logic irq;
    logic [31:0] rdata;
  } wwt_state_type;
endpackage

// file: rtl/wwt_tick.sv
// tick divider of the window timer
`timescale 1ns/1ps
`include "wwt_cfg.svh"
module wwt_tick #(
  parameter int PRE_DIV = `WWT_PRE_DIV
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic run,
  input wire logic [1:0] tb,
  output logic tick
);
  // refuse a prescale that the 16-bit counter cannot reach
  if (PRE_DIV < 2 || PRE_DIV > 65536) begin : g_bad_div
    $error("wwt_tick: PRE_DIV out of range");
  end
  logic [15:0] pre_reg;
  logic [2:0] sub_reg;
  logic [2:0] sub_max;
  logic pre_end;
  always_comb begin
    unique case (tb)
      2'h0: sub_max = 3'h0;
      2'h1: sub_max = 3'h1;
      2'h2: sub_max = 3'h3;
      2'h3: sub_max = 3'h7;
    endcase
  end
  assign pre_end = (pre_reg == 16'(PRE_DIV - 1));
  // divide by prescale then by power of two
  always_ff @(posedge mclk) begin
    if (reset) begin
      pre_reg <= 16'h0000;
      sub_reg <= 3'h0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (run) begin
        pre_reg <= pre_end ? 16'h0000 : pre_reg + 16'h0001;
        if (pre_end) begin
          if (sub_reg >= sub_max) begin
            sub_reg <= 3'h0;
            tick <= 1'b1;
          end else begin
            sub_reg <= sub_reg + 3'h1;
          end
        end
      end
    end
  end
endmodule // wwt_tick

// file: rtl/wwt_top.sv
// window watchdog timer with register port
`timescale 1ns/1ps
`include "wwt_cfg.svh"
module wwt_top #(
  parameter int PRE_DIV = `WWT_PRE_DIV
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  input wire logic core_halted,
  input wire logic debug_freeze_control,
  output logic sys_reset_req,
  output logic irq
);
  wwt_pkg::wwt_state_type s_reg;
  wwt_pkg::wwt_state_type s_next;
  logic halt_s1_reg;
  logic halt_s2_reg;
  logic frz_s1_reg;
  logic frz_s2_reg;
  logic run;
  logic tick;
  logic wr_ctrl;
  logic wr_cfg;
  logic wr_sts;
  logic wr_ien;
  logic hit_early;
  logic hit_last;

  // refuse a prescale the tick divider cannot count
  if (PRE_DIV < 2 || PRE_DIV > 65536) begin : g_bad_div
    $error("wwt_top: PRE_DIV out of range");
  end

  // debug lines come from another domain
  always_ff @(posedge mclk) begin
    if (reset) begin
      halt_s1_reg <= 1'b0;
      halt_s2_reg <= 1'b0;
      frz_s1_reg <= 1'b0;
      frz_s2_reg <= 1'b0;
    end else begin
      halt_s1_reg <= core_halted;
      halt_s2_reg <= halt_s1_reg;
      frz_s1_reg <= debug_freeze_control;
      frz_s2_reg <= frz_s1_reg;
    end
  end

  assign run = !(halt_s2_reg && frz_s2_reg);

  wwt_tick #(
    .PRE_DIV(PRE_DIV)
  ) u_tick (
    .mclk(mclk),
    .reset(reset),
    .run(run),
    .tb(s_reg.tb),
    .tick(tick)
  );

  assign wr_ctrl = wr_stb && (addr == `WWT_OFS_CTRL);
  assign wr_cfg = wr_stb && (addr == `WWT_OFS_CFG);
  assign wr_sts = wr_stb && (addr == `WWT_OFS_STS);
  assign wr_ien = wr_stb && (addr == `WWT_OFS_IEN);
  assign hit_early = tick && run && (s_reg.cnt == `WWT_CNT_EARLY);
  assign hit_last = hit_early;

  always_comb begin
    s_next = s_reg;
    s_next.pre = 12'h000;
    s_next.sub = 3'h0;
    s_next.rdata = 32'h00000000;
    // decrement on each tick, wrapping when idle
    if (tick && run) begin
      s_next.cnt = s_reg.cnt - 14'h0001;
    end
    if (wr_ctrl) begin
      s_next.cnt = wdata[13:0];
      if (wdata[`WWT_BIT_ACT]) begin
        s_next.act = 1'b1;
      end
      if (s_reg.act && (s_reg.cnt > s_reg.win)) begin
        s_next.rst_req = 1'b1;
      end
    end
    // reset on 0x40 to 0x3F while active
    if (s_reg.act && hit_last && !wr_ctrl) begin
      s_next.rst_req = 1'b1;
    end
    if (wr_cfg) begin
      s_next.win = wdata[13:0];
      s_next.tb = wdata[15:14];
      if (wdata[`WWT_BIT_EWI]) begin
        s_next.ewi = 1'b1;
      end
    end
    // write zero clears, write one keeps
    if (wr_sts && !wdata[0]) begin
      s_next.flag = 1'b0;
    end
    // clear register of the same layout
    if (wr_ien && wdata[0]) begin
      s_next.flag = 1'b0;
    end
    if (hit_early) begin
      s_next.flag = 1'b1;
    end
    // level interrupt when started and enabled
    s_next.irq = s_next.flag && s_next.ewi && s_next.act;
    if (rd_stb) begin
      unique case (addr)
        `WWT_OFS_CTRL: s_next.rdata = {17'h00000, s_reg.act, s_reg.cnt};
        `WWT_OFS_CFG: s_next.rdata = {15'h0000, s_reg.ewi, s_reg.tb,
          s_reg.win};
        `WWT_OFS_STS: s_next.rdata = {31'h00000000, s_reg.flag};
        default: s_next.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_reg.pre <= 12'h000;
      s_reg.sub <= 3'h0;
      s_reg.cnt <= `WWT_CNT_RST;
      s_reg.win <= `WWT_WIN_RST;
      s_reg.tb <= 2'h0;
      s_reg.act <= 1'b0;
      s_reg.ewi <= 1'b0;
      s_reg.flag <= 1'b0;
      s_reg.rst_req <= 1'b0;
      s_reg.irq <= 1'b0;
      s_reg.rdata <= 32'h00000000;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign sys_reset_req = s_reg.rst_req;
  assign irq = s_reg.irq;

  // steps of the low-count reset and of the interrupt
  sequence seq_low_tick;
    s_reg.act && hit_last && !wr_ctrl;
  endsequence
  sequence seq_at_last;
    (s_reg.cnt == `WWT_CNT_LAST) && s_reg.rst_req;
  endsequence
  sequence seq_flag_up;
    hit_early && s_reg.ewi && s_reg.act;
  endsequence
  sequence seq_irq_up;
    irq && s_reg.flag;
  endsequence

  AST_ACT_STICKY: assert property (@(posedge mclk) disable iff (reset)
    s_reg.act |=> s_reg.act)
    else $error("activation bit dropped");
  AST_LOW_RESET: assert property (@(posedge mclk) disable iff (reset)
    (s_reg.act && hit_last && !wr_ctrl) |=> s_reg.rst_req)
    else $error("no reset below 0x40");
  AST_EARLY_REFRESH: assert property (
    @(posedge mclk) disable iff (reset)
    (wr_ctrl && s_reg.act && s_reg.cnt > s_reg.win) |=> s_reg.rst_req)
    else $error("no reset on early refresh");
  AST_REFRESH_LOAD: assert property (
    @(posedge mclk) disable iff (reset)
    wr_ctrl |=> s_reg.cnt == $past(wdata[13:0]))
    else $error("refresh did not load counter");
  AST_DECREMENT: assert property (@(posedge mclk) disable iff (reset)
    (tick && run && !wr_ctrl) |=> s_reg.cnt == $past(s_reg.cnt) - 14'h0001)
    else $error("counter did not decrement");
  AST_FREEZE: assert property (@(posedge mclk) disable iff (reset)
    (!run && !wr_ctrl) |=> $stable(s_reg.cnt))
    else $error("counter moved while frozen");
  AST_FLAG_SET: assert property (@(posedge mclk) disable iff (reset)
    hit_early |=> s_reg.flag)
    else $error("early flag not set");
  AST_FLAG_KEEP: assert property (@(posedge mclk) disable iff (reset)
    (wr_sts && wdata[0] && s_reg.flag) |=> s_reg.flag)
    else $error("flag cleared by write of one");
  AST_EWI_STICKY: assert property (@(posedge mclk) disable iff (reset)
    s_reg.ewi |=> s_reg.ewi)
    else $error("interrupt enable dropped");
  AST_IRQ: assert property (@(posedge mclk) disable iff (reset)
    irq == (s_reg.flag && s_reg.ewi && s_reg.act))
    else $error("interrupt level wrong");

  AST_ACT_SET: assert property (
    @(posedge mclk) disable iff (reset)
    (wr_ctrl && wdata[`WWT_BIT_ACT]) |=> s_reg.act
  )
    else $error("activation not set");

  // idle stays idle without a set
  AST_ACT_HOLD: assert property (
    @(posedge mclk) disable iff (reset)
    (!s_reg.act && !(wr_ctrl && wdata[`WWT_BIT_ACT])) |=> !s_reg.act
  )
    else $error("activation rose without write");

  AST_REQ_STICKY: assert property (
    @(posedge mclk) disable iff (reset)
    s_reg.rst_req |=> s_reg.rst_req
  )
    else $error("reset request dropped");

  AST_REQ_QUIET: assert property (
    @(posedge mclk) disable iff (reset)
    (!s_reg.act && !s_reg.rst_req) |=> !s_reg.rst_req
  )
    else $error("reset request while idle");

  // last tick lands on 0x3F with request
  AST_LAST_COUNT: assert property (
    @(posedge mclk) disable iff (reset)
    seq_low_tick |=> seq_at_last
  )
    else $error("timeout did not end at 0x3F");

  AST_LATE_OK: assert property (
    @(posedge mclk) disable iff (reset)
    (wr_ctrl && s_reg.act && s_reg.cnt <= s_reg.win && !s_reg.rst_req)
    |=> !s_reg.rst_req
  ) else $error("reset on refresh inside window");

  AST_WRAP: assert property (
    @(posedge mclk) disable iff (reset)
    (tick && run && !wr_ctrl && s_reg.cnt == 14'h0000) |=> s_reg.cnt == 14'h3FFF
  )
    else $error("counter did not wrap");

  AST_WIN_LOAD: assert property (
    @(posedge mclk) disable iff (reset)
    wr_cfg |=> s_reg.win == $past(wdata[13:0])
  )
    else $error("window not loaded");

  AST_TB_LOAD: assert property (
    @(posedge mclk) disable iff (reset)
    wr_cfg |=> s_reg.tb == $past(wdata[15:14])
  )
    else $error("timebase not loaded");

  AST_EWI_SET: assert property (
    @(posedge mclk) disable iff (reset)
    (wr_cfg && wdata[`WWT_BIT_EWI]) |=> s_reg.ewi
  )
    else $error("interrupt enable not set");

  AST_EWI_HOLD: assert property (
    @(posedge mclk) disable iff (reset)
    (!s_reg.ewi && !(wr_cfg && wdata[`WWT_BIT_EWI])) |=> !s_reg.ewi
  )
    else $error("interrupt enable rose alone");

  AST_FLAG_CLEAR: assert property (
    @(posedge mclk) disable iff (reset)
    (wr_sts && !wdata[0] && !hit_early) |=> !s_reg.flag
  )
    else $error("flag not cleared by zero");

  AST_FLAG_HOLD: assert property (
    @(posedge mclk) disable iff (reset)
    (!hit_early && !wr_sts && !wr_ien) |=> $stable(s_reg.flag)
  )
    else $error("flag moved without event");

  AST_TICK_PULSE: assert property (
    @(posedge mclk) disable iff (reset)
    tick |=> !tick
  )
    else $error("tick longer than one cycle");

  AST_SYNC_HALT: assert property (
    @(posedge mclk) disable iff (reset)
    !$past(reset) |-> halt_s2_reg == $past(halt_s1_reg)
  )
    else $error("halt synchroniser skipped");

  AST_SYNC_FRZ: assert property (
    @(posedge mclk) disable iff (reset)
    !$past(reset) |-> frz_s2_reg == $past(frz_s1_reg)
  )
    else $error("freeze synchroniser skipped");

  AST_IRQ_RISE: assert property (
    @(posedge mclk) disable iff (reset)
    seq_flag_up |=> seq_irq_up
  )
    else $error("interrupt did not rise");

  AST_READ_CTRL: assert property (
    @(posedge mclk) disable iff (reset)
    (rd_stb && addr == `WWT_OFS_CTRL)
    |=> rdata == {17'h00000, $past(s_reg.act), $past(s_reg.cnt)}
  ) else $error("counter readback wrong");

  AST_READ_STS: assert property (
    @(posedge mclk) disable iff (reset)
    (rd_stb && addr == `WWT_OFS_STS)
    |=> rdata == {31'h00000000, $past(s_reg.flag)}
  ) else $error("flag readback wrong");

  AST_HOLD_NO_TICK: assert property (
    @(posedge mclk) disable iff (reset)
    (!(tick && run) && !wr_ctrl) |=> $stable(s_reg.cnt)
  )
    else $error("counter moved without tick");
endmodule // wwt_top

// file: verification/test_wwt_top.sv
// self-checking bench of the window timer
`timescale 1ns/1ps
module test_wwt_top;
  // short prescale keeps the run brief
  localparam int PD = 4;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic core_halted = 1'b0;
  logic debug_freeze_control = 1'b0;
  logic [31:0] rdata;
  logic sys_reset_req;
  logic irq;
  logic [31:0] v;
  logic [31:0] w;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  always #4 mclk = ~mclk;
  wwt_top #(.PRE_DIV(PD)) dut (.mclk(mclk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .core_halted(core_halted), .debug_freeze_control(debug_freeze_control),
    .sys_reset_req(sys_reset_req), .irq(irq));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask
  // range compare; exact when lo equals hi
  task automatic chk(input logic [31:0] g, input logic [31:0] lo,
      input logic [31:0] hi, input string m);
    num_checks++;
    if (!((g >= lo) === 1'b1 && (g <= hi) === 1'b1)) begin
      $display("wrong value at %0t: %s got %h", $time, m, g);
      bad_count++;
    end
  endtask
  task automatic rst(input int n);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (n) @(posedge mclk);
    reset <= 1'b0;
  endtask
  initial begin
    rst(12);
    rd(4'h4, v);
    chk(v, 32'h3FFF, 32'h3FFF, "cfg reset"); // window reset
    rd(4'h8, v);
    chk(v, 32'h0, 32'h0, "flag reset"); // flag clear
    rd(4'h2, v);
    chk(v, 32'h0, 32'h0, "unmapped");
    $display("test reset values done");
    for (int t = 0; t < 4; t++) begin
      wr(4'h4, {16'h0, t[1:0], 14'h3FFF});
      wr(4'h0, 32'h1000);
      wt(40 * (PD << t));
      rd(4'h0, v);
      chk(v, 32'h0FD5, 32'h0FD9, "tick rate"); // rate
    end
    core_halted <= 1'b1;
    debug_freeze_control <= 1'b1;
    wt(8);
    rd(4'h0, v);
    wt(100);
    rd(4'h0, w);
    chk(w, v, v, "frozen"); // halted stop
    debug_freeze_control <= 1'b0;
    wt(320);
    rd(4'h0, v);
    chk(v, w - 12, w - 8, "not frozen"); // halted run
    core_halted <= 1'b0;
    $display("test timebase done");
    rst(2);
    wr(4'h0, 32'h0050);
    wt(100);
    rd(4'h8, v);
    chk(v, 32'h1, 32'h1, "flag"); // flag idle
    chk({30'h0, irq, sys_reset_req}, 0, 0, "idle out"); // gated
    wr(4'h8, 32'h1);
    rd(4'h8, v);
    chk(v, 32'h1, 32'h1, "flag kept"); // one ignored
    wr(4'h8, 32'h0);
    rd(4'h8, v);
    chk(v, 32'h0, 32'h0, "flag clr"); // zero clears
    $display("test early flag done");
    rst(2);
    wr(4'h4, 32'h0001_3FFF);
    wr(4'h0, 32'h0000_4048); // activation bit 14 set, count 0x48
    wt(28);
    chk({30'h0, irq, sys_reset_req}, 0, 0, "early"); // not yet
    wt(12);
    chk({30'h0, irq, sys_reset_req}, 3, 3, "timeout");
    wr(4'h8, 32'h0);
    wt(3);
    chk({30'h0, irq, sys_reset_req}, 1, 1, "irq off"); // sticky req
    $display("test timeout done");
    rst(2);
    wr(4'h0, 32'h0000_6000); // activate with high count
    wr(4'h0, 32'h0000_2000);
    rd(4'h0, v);
    chk(v, 32'h5FF0, 32'h6000, "act kept"); // refresh
    wr(4'h4, 32'h0001_0100);
    wr(4'h4, 32'h0000_0100);
    rd(4'h4, v);
    chk(v, 32'h0001_0100, 32'h0001_0100, "ien kept");
    chk({31'h0, sys_reset_req}, 0, 0, "legal"); // inside window
    wr(4'h0, 32'h0000_2000);
    wt(2);
    chk({31'h0, sys_reset_req}, 1, 1, "refresh early"); // above win
    $display("test window done");
    end_sim();
  end
endmodule // test_wwt_top
